// ==== rtl/asr_pkg.sv ====
/*
  Package of the host-side controller for an 8K x 8 asynchronous static RAM:
  widths, pin carrier, speed-grade timing and derived cycle counts.
  Assumes a 200 MHz system clock.
*/
package asr_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned INDEX_W = 13;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned CNT_W   = 8;

  // ****************************************************************
  // Timing (slowest grade, ns) and clock
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 5;
  localparam int unsigned INDEX_ACCESS_NS    = 85;
  localparam int unsigned SELECT_ACCESS_NS   = 85;
  localparam int unsigned GATE_ACCESS_NS     = 35;
  localparam int unsigned SELECT_FLOAT_NS    = 35;
  localparam int unsigned GATE_FLOAT_NS      = 30;
  localparam int unsigned STROBE_FLOAT_NS    = 35;
  localparam int unsigned STROBE_PULSE_NS    = 45;
  localparam int unsigned SELECT_WRITE_NS    = 65;

  function automatic logic [CNT_W-1:0] ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : ns_to_cyc

  // Read waits the longest of address, select and gate access
  localparam logic [CNT_W-1:0] READ_CYC   = ns_to_cyc(INDEX_ACCESS_NS);
  // One cycle of sampling margin plus two synchroniser stages
  localparam logic [CNT_W-1:0] SYNC_CYC   = 8'h03;
  // Write: select held over the strobe, strobe at least its minimum
  localparam logic [CNT_W-1:0] WRITE_CYC  = ns_to_cyc(SELECT_WRITE_NS);
  localparam logic [CNT_W-1:0] STROBE_CYC = ns_to_cyc(STROBE_PULSE_NS);
  // Bus turnaround after the device lets go of the data lines
  localparam logic [CNT_W-1:0] FLOAT_CYC  = ns_to_cyc(SELECT_FLOAT_NS);

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic               select_low_active_n;
    logic               select_high_active;
    logic               strobe_n;
    logic               gate_n;
    logic [INDEX_W-1:0] word_index;
  } asr_pins_type;

  typedef struct packed {
    logic               write;
    logic [INDEX_W-1:0] index;
    logic [DATA_W-1:0]  data;
  } asr_req_type;

endpackage : asr_pkg

// ==== rtl/asr_host.sv ====
/*
  Host controller for an 8K x 8 asynchronous static RAM. Takes one request
  at a time, drives the memory pins with strobes timed by cycle counters and
  returns read data.
  Assumes memory pins reach the device directly; the bench resolves the
  shared data lines from the output enable.
*/
// Operation
// RULE_01: Memory holds 8192 words of eight bits, one per address.
// RULE_02: One eight-bit data bus; host drives only during writes.
// RULE_03: Read data returns bit-for-bit as written, no inversion.
// RULE_04: Host selects word over thirteen address lines, bits 0 to 12.
// RULE_05: Read: address, selects active, strobe high; data within access.
// RULE_06: Device floats outputs when deselected or strobe low.
// RULE_07: Write happens only while both selects active and strobe low.
// RULE_08: Write ends when any select or the strobe is removed.
// RULE_09: Device is clockless; read cycle equals access time.
// RULE_10: Device powers down itself on long accesses or deselect.
// RULE_11: Power-down follows access start within 85 ns worst grade.
// RULE_12: Read data valid within 85 ns of address settling.
// RULE_13: Old data holds at least 5 ns after address change.
// RULE_14: Read data valid within 85 ns of select active.
// RULE_15: Read data valid within 35 ns of gate falling.
// RULE_16: Outputs float within 35 ns of select going inactive.
// RULE_17: Outputs float within 30 ns of gate rising.
// RULE_18: Outputs float within 35 ns of strobe falling.
// RULE_19: Host holds strobe low at least 45 ns to write end.
// RULE_20: Host holds select active at least 65 ns to write end.
// RULE_21: Host keeps select off or strobe high while address changes.
// RULE_22: Strobe falling before select keeps device outputs floating.
// RULE_23: Device drives only with gate low; host releases bus first.
module asr_host (
  // Clock and control
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  // User request
  input  wire logic                       req_valid,
  input  wire asr_pkg::asr_req_type       req,
  output logic                            req_ready,
  // User answer
  output logic                            rsp_valid,
  output logic [asr_pkg::DATA_W-1:0]      rsp_data,
  // Memory pins
  output asr_pkg::asr_pins_type           pins,
  output logic [asr_pkg::DATA_W-1:0]      shared_data_line_o,
  output logic                            shared_data_line_oe,
  input  wire logic [asr_pkg::DATA_W-1:0] shared_data_line_i
);

  typedef enum logic [2:0] {
    IDLE, RD_ACCESS, RD_FLOAT, WR_SETUP, WR_STROBE, WR_END
  } asr_state_type;

  // ****************************************************************
  // Data line synchroniser
  // ****************************************************************
  logic [asr_pkg::DATA_W-1:0] sync1_ff, sync2_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else if (clk_en) begin
      sync1_ff <= shared_data_line_i;
      sync2_ff <= sync1_ff;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  asr_state_type              state_ff, nxt_state;
  logic [asr_pkg::CNT_W-1:0]  cnt_ff, nxt_cnt;
  asr_pkg::asr_pins_type      pins_ff, nxt_pins;
  logic [asr_pkg::DATA_W-1:0] dout_ff, nxt_dout;
  logic                       oe_ff, nxt_oe;
  logic                       ready_ff, nxt_ready;
  logic                       rvalid_ff, nxt_rvalid;
  logic [asr_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;

  localparam asr_pkg::asr_pins_type PINS_IDLE = '{
    select_low_active_n: 1'b1, select_high_active: 1'b0,
    strobe_n: 1'b1, gate_n: 1'b1, word_index: 13'h0000};

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_pins   = pins_ff;
    nxt_dout   = dout_ff;
    nxt_oe     = oe_ff;
    nxt_ready  = ready_ff;
    nxt_rvalid = 1'b0;
    nxt_rdata  = rdata_ff;
    unique case (state_ff)
      IDLE: begin
        if (req_valid && ready_ff) begin
          nxt_ready = 1'b0;
          // Address set on the same edge that asserts both selects, strobe high
          nxt_pins.word_index          = req.index; // RULE_04 RULE_21
          nxt_pins.select_low_active_n = 1'b0;
          nxt_pins.select_high_active  = 1'b1;
          if (req.write) begin
            // Gate stays high, host owns the bus
            nxt_dout  = req.data; // RULE_03
            nxt_oe    = 1'b1; // RULE_02
            nxt_cnt   = asr_pkg::WRITE_CYC - asr_pkg::STROBE_CYC;
            nxt_state = WR_SETUP;
          end else begin
            // Bus already released before gate goes low
            nxt_oe           = 1'b0; // RULE_23
            nxt_pins.gate_n  = 1'b0; // RULE_05
            nxt_cnt          = asr_pkg::READ_CYC + asr_pkg::SYNC_CYC;
            nxt_state        = RD_ACCESS;
          end
        end
      end
      RD_ACCESS: begin
        // Pin sampled one cycle past access time, then two sync stages
        if (cnt_ff == 8'h01) begin
          nxt_rdata  = sync2_ff; // RULE_12 RULE_14 RULE_15
          nxt_rvalid = 1'b1;
          nxt_pins   = PINS_IDLE; // RULE_16 RULE_17
          nxt_cnt    = asr_pkg::FLOAT_CYC;
          nxt_state  = RD_FLOAT;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      RD_FLOAT: begin
        // Wait out the device float delay before any host drive
        if (cnt_ff == 8'h01) begin
          nxt_ready = 1'b1;
          nxt_state = IDLE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      WR_SETUP: begin
        // Select leads strobe so select-to-end covers its minimum
        if (cnt_ff == 8'h01) begin
          nxt_pins.strobe_n = 1'b0; // RULE_07
          nxt_cnt           = asr_pkg::STROBE_CYC;
          nxt_state         = WR_STROBE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      WR_STROBE: begin
        if (cnt_ff == 8'h01) begin
          // Strobe rises first and ends the write; data held past it
          nxt_pins.strobe_n = 1'b1; // RULE_08 RULE_19 RULE_20
          nxt_state         = WR_END;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      WR_END: begin
        nxt_pins  = PINS_IDLE;
        nxt_oe    = 1'b0; // RULE_02
        nxt_ready = 1'b1;
        nxt_state = IDLE;
      end
      default: begin
        nxt_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff  <= IDLE;
      cnt_ff    <= 8'h00;
      pins_ff   <= PINS_IDLE;
      dout_ff   <= 8'h00;
      oe_ff     <= 1'b0;
      ready_ff  <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 8'h00;
    end else if (clk_en) begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pins_ff   <= nxt_pins;
      dout_ff   <= nxt_dout;
      oe_ff     <= nxt_oe;
      ready_ff  <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign req_ready           = ready_ff;
  assign rsp_valid           = rvalid_ff;
  assign rsp_data            = rdata_ff;
  assign pins                = pins_ff;
  assign shared_data_line_o  = dout_ff;
  assign shared_data_line_oe = oe_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [asr_pkg::CNT_W-1:0] lowcnt_ff;
  always_ff @(posedge clk) begin
    if (srst || pins_ff.strobe_n) begin
      lowcnt_ff <= 8'h00;
    end else if (clk_en && lowcnt_ff != 8'hFF) begin
      lowcnt_ff <= lowcnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge clk iff clk_en); endclocking
  default disable iff (srst);

  a_bus_no_clash: assert property ( // RULE_02
    oe_ff |-> pins_ff.gate_n) else $error("host drives bus with gate low");
  a_gate_release: assert property ( // RULE_23
    $fell(pins_ff.gate_n) |-> !oe_ff) else $error("gate low while driving");
  a_strobe_width: assert property ( // RULE_19
    $rose(pins_ff.strobe_n) |-> lowcnt_ff >= asr_pkg::STROBE_CYC)
    else $error("strobe pulse too short");
  a_index_stable: assert property ( // RULE_21
    !pins_ff.strobe_n |=> $stable(pins_ff.word_index))
    else $error("address moved during write");
  a_write_select: assert property ( // RULE_07
    !pins_ff.strobe_n |-> !pins_ff.select_low_active_n
      && pins_ff.select_high_active) else $error("strobe without select");
  a_read_strobe: assert property ( // RULE_05
    !pins_ff.gate_n |-> pins_ff.strobe_n) else $error("strobe in read");
  a_write_end: assert property ( // RULE_08 RULE_20
    $rose(pins_ff.strobe_n) |-> !pins_ff.select_low_active_n ##1
      pins_ff.select_low_active_n) else $error("bad write end order");
  a_read_answer: assert property ( // RULE_12
    $fell(pins_ff.gate_n) |-> ##20 rsp_valid) else $error("read late");

  c_read: cover property ($rose(rsp_valid));
  c_write: cover property ($rose(pins_ff.strobe_n));
  c_back: cover property (rsp_valid ##[1:12] !pins_ff.strobe_n);

endmodule : asr_host

// ==== verification/asr_sram_model.sv ====
/*
  Behavioural 8K x 8 static RAM on the far side of the host controller.
  Assumes the bench feeds bus back to the host data input.
*/
module asr_sram_model #(
  parameter int ACC_NS = 85
) (
  // Memory pins
  input  wire asr_pkg::asr_pins_type pins,
  input  wire logic [7:0]            host_d,
  input  wire logic                  host_oe,
  // Resolved data lines, misuse flag, power-down flag
  output logic [7:0]                 bus,
  output logic                       viol,
  output logic                       pdown
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Storage
  // ****************
  logic [7:0] mem [8192];
  logic       sel;
  logic       rd_en;
  logic       wr_en;
  logic       wr_on;
  realtime    t_chg;
  realtime    t_sel;
  realtime    t_str;
  assign sel   = !pins.select_low_active_n && pins.select_high_active;
  assign rd_en = sel && pins.strobe_n && !pins.gate_n;
  assign wr_en = sel && !pins.strobe_n;
  initial begin
    bus   = 8'h00;
    viol  = 1'h0;
    wr_on = 1'h0;
    pdown = 1'h1;
  end
  always @(rd_en or pins.word_index) t_chg = $realtime;
  always @(posedge sel) t_sel = $realtime;
  always @(negedge pins.strobe_n) t_str = $realtime;
  always @(posedge wr_en) wr_on = 1'h1;
  // Released lines toggle so no stale value survives
  always #1 begin
    if (host_oe && rd_en) viol = 1'h1;
    pdown = !sel || $realtime - t_chg >= ACC_NS;
    if (host_oe) bus = host_d;
    else if (rd_en && $realtime - t_chg < 5) bus = bus;
    else if (rd_en && $realtime - t_chg >= ACC_NS)
      bus = mem[pins.word_index];
    else bus = ~bus;
  end
  always @(pins.word_index) if (wr_en) viol = 1'h1;
  always @(negedge wr_en) if (wr_on) begin
    if (!host_oe || $realtime - t_str < 45) viol = 1'h1;
    if ($realtime - t_sel < 65) viol = 1'h1;
    mem[pins.word_index] = host_d;
    wr_on = 1'h0;
  end
endmodule : asr_sram_model

// ==== verification/testbench.sv ====
/*
  Self-checking bench of the host controller against the memory model.
  Assumes a 200 MHz clock and the model's bus fed back as read data.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [16:0] IDLE = {4'hB, 13'h0000};
  logic                  clk;
  logic                  srst;
  logic                  clk_en;
  logic                  req_valid;
  asr_pkg::asr_req_type  req;
  logic                  req_ready;
  logic                  rsp_valid;
  logic [7:0]            rsp_data;
  asr_pkg::asr_pins_type pins;
  logic [7:0]            d_o;
  logic                  d_oe;
  logic [7:0]            bus;
  logic                  viol;
  logic                  pdown;
  logic [7:0]            q;
  int                    errors;
  int                    cmp_count;
  int                    n;
  int                    m;
  asr_host asr_host_i (.clk(clk), .srst(srst), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
    .shared_data_line_o(d_o), .shared_data_line_oe(d_oe),
    .shared_data_line_i(bus));
  asr_sram_model asr_sram_model_i (.pins(pins), .host_d(d_o),
    .host_oe(d_oe), .bus(bus), .viol(viol), .pdown(pdown));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string s, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", s, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("Checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // One request; n answer latency, m cycles until ready again
  task automatic op(input logic w, input logic [12:0] a,
                    input logic [7:0] d, input int frz, pk);
    @(negedge clk);
    req_valid = 1'h1;
    req       = '{write: w, index: a, data: d};
    while (req_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'h0;
    clk_en    = (frz == 0);
    n         = 0;
    while (n < 60 && (w ? req_ready : rsp_valid) !== 1'h1) begin
      @(negedge clk);
      n++;
      if (n >= frz) clk_en = 1'h1;
      if (pk && n == 4) req = '{1'h1, 13'h0000, 8'hFF};
      if (pk) req_valid = (n >= 4 && n < 6);
      if (!w && d_oe !== 1'h0) chk("rd_oe", 0, 32'(d_oe));
    end
    q = rsp_data;
    m = n;
    if (!w) begin
      @(negedge clk);
      m++;
      chk("rsp_pulse", 0, 32'(rsp_valid));
      while (m < 90 && req_ready !== 1'h1) begin
        @(negedge clk);
        m++;
      end
    end
  endtask : op
  function automatic logic [12:0] ix(input int i);
    return (i < 13) ? 13'(1 << i) : 13'h0000;
  endfunction : ix
  task automatic t_walk();
    for (int i = 0; i < 14; i++) begin
      op(1'h1, ix(i), ~8'(i * 19), 0, 0);
      chk("wr_lat", 14, n);
    end
    for (int i = 0; i < 14; i++) begin
      op(1'h0, ix(i), 8'h00, 0, 0);
      chk("rd_data", {24'h000000, ~8'(i * 19)}, 32'(q));
      chk("rd_lat", 20, n);
      chk("rd_ready", 27, m);
      chk("rd_pins", 32'(IDLE), 32'(pins));
      chk("rd_pdown", 1, 32'(pdown));
    end
  endtask : t_walk
  task automatic t_freeze_refuse();
    op(1'h0, 13'h0001, 8'h00, 5, 0);
    chk("frz_lat", 25, n);
    chk("frz_data", {24'h000000, ~8'(0)}, 32'(q));
    op(1'h1, 13'h1FFF, 8'h77, 0, 1);
    op(1'h0, 13'h0000, 8'h00, 0, 0);
    chk("refused", {24'h000000, ~8'(13 * 19)}, 32'(q));
    op(1'h0, 13'h1FFF, 8'h00, 0, 0);
    chk("top_word", 32'h77, 32'(q));
  endtask : t_freeze_refuse
  task automatic t_abort();
    op(1'h1, 13'h0002, 8'h00, 3, 0);
    @(negedge clk);
    req       = '{write: 1'h1, index: 13'h0002, data: 8'h55};
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    repeat (2) @(negedge clk);
    srst = 1'h1;
    @(negedge clk);
    srst = 1'h0;
    chk("rst_pins", 32'(IDLE), 32'(pins));
    chk("rst_ready", 1, 32'(req_ready));
    op(1'h0, 13'h0002, 8'h00, 0, 0);
    chk("abort_data", 32'h00, 32'(q));
  endtask : t_abort
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #60000;
    errors++;
    end_sim();
  end
  initial begin
    srst      = 1'h1;
    clk_en    = 1'h1;
    req_valid = 1'h0;
    req       = '0;
    errors    = 0;
    cmp_count = 0;
    repeat (10) @(negedge clk);
    srst = 1'h0;
    chk("idle_pins", 32'(IDLE), 32'(pins));
    chk("idle_oe", 0, 32'(d_oe));
    t_walk();
    t_freeze_refuse();
    t_abort();
    chk("model_ok", 0, 32'(viol));
    end_sim();
  end
endmodule : testbench
